/* File: mrp_device.sv */
`timescale 1ns/1ps
// What this block does
// - data bus 512 full, 256 half
// - client writes at most 128 payload bytes
// - full-width write takes at most 2 beats
// - half-width write takes at most 4 beats
// - short last beat uses low data bits
// - full 1 to 4 ports, half one
// - each port uses only its tag range
// - client gives well-formed destination address
// - non-posted tags unique while in flight
// - tag reused only after completion
// - client gives correct 3-bit cube id
// - issue only when response can be taken
// - all signals synchronous to core clock
// - beat taken only when ready and valid
// - drop ready when unable to accept
// - ready held through multi-beat write
// - valid held across write beats
// - tag and command held across beats
// - tag ranges split per port count
// - tag ignored on posted requests
module mrp_device #(
  parameter bit FULL_WIDTH = 1'b1,
  parameter int DATA_W     = mrp_pkg::MRP_DATA_W_FULL
) (
  input  wire logic                          rst_n,
  mrp_if.device                              req,
  input  wire logic                          sink_ready,
  output logic                               sink_hdr_valid,
  output logic [mrp_pkg::MRP_ADDR_W-1:0]     sink_addr,
  output logic [mrp_pkg::MRP_TAG_W-1:0]      sink_tag,
  output logic [mrp_pkg::MRP_CUB_W-1:0]      sink_cube,
  output logic [mrp_pkg::MRP_CMD_W-1:0]      sink_command,
  output logic [mrp_pkg::MRP_LEN_W-1:0]      sink_len,
  output logic                               sink_write,
  output logic                               sink_posted,
  output logic                               sink_data_valid,
  output logic [DATA_W-1:0]                  sink_data,
  output logic                               sink_last
);
  import mrp_pkg::*;

  // one request port per instance, bus width set by DATA_W
  localparam int BYTES_PER_BEAT = DATA_W / 8;

  typedef enum logic [1:0] {
    MRP_IDLE,
    MRP_BURST
  } mrp_state_e;

  mrp_state_e                 state_q, state_d;
  logic [MRP_BEAT_CNT_W-1:0]  left_q, left_d;
  logic                       hdr_v_q, hdr_v_d;
  logic [MRP_ADDR_W-1:0]      addr_q, addr_d;
  logic [MRP_TAG_W-1:0]       tag_q, tag_d;
  logic [MRP_CUB_W-1:0]       cube_q, cube_d;
  logic [MRP_CMD_W-1:0]       cmd_q, cmd_d;
  logic [MRP_LEN_W-1:0]       len_q, len_d;
  logic                       wr_q, wr_d;
  logic                       pst_q, pst_d;
  logic                       dv_q, dv_d;
  logic                       last_q, last_d;
  logic [DATA_W-1:0]          data_q, data_d;
  logic                       take;
  logic [MRP_BEAT_CNT_W-1:0]  beats;

  // inside a burst ready stays high; otherwise only when output slot is free
  always_comb begin
    case (state_q)
      MRP_IDLE: begin
        req.port_accept_ready = sink_ready;
      end
      MRP_BURST: begin
        req.port_accept_ready = 1'b1;
      end
      default: begin
        req.port_accept_ready = 1'b0;
      end
    endcase
  end

  assign take  = req.port_accept_ready && req.port_request_valid;
  assign beats = req.port_request_write ?
                 mrp_beats(req.port_request_len, BYTES_PER_BEAT) : MRP_BEAT_CNT_W'(1);

  // burst control: beats still owed after the first one
  always_comb begin
    state_d = state_q;
    left_d  = left_q;
    case (state_q)
      MRP_IDLE: begin
        if (take && beats > MRP_BEAT_CNT_W'(1)) begin
          state_d = MRP_BURST;
          left_d  = beats - MRP_BEAT_CNT_W'(1);
        end
      end
      MRP_BURST: begin
        if (take) begin
          left_d = left_q - MRP_BEAT_CNT_W'(1);
          if (left_q == MRP_BEAT_CNT_W'(1)) begin
            state_d = MRP_IDLE;
          end
        end
      end
      default: begin
        state_d = MRP_IDLE;
      end
    endcase
  end

  always_ff @(posedge req.clk) begin
    if (!rst_n) begin
      state_q <= MRP_IDLE;
      left_q  <= '0;
    end else begin
      state_q <= state_d;
      left_q  <= left_d;
    end
  end

  // header fields come from the first beat only
  always_comb begin
    hdr_v_d = 1'b0;
    addr_d  = addr_q;
    tag_d   = tag_q;
    cube_d  = cube_q;
    cmd_d   = cmd_q;
    len_d   = len_q;
    wr_d    = wr_q;
    pst_d   = pst_q;
    if (take && state_q == MRP_IDLE) begin
      hdr_v_d = 1'b1;
      addr_d  = req.port_request_addr;
      cube_d  = req.port_request_cube;
      cmd_d   = req.port_request_command;
      len_d   = req.port_request_len;
      wr_d    = req.port_request_write;
      pst_d   = req.port_request_posted;
      tag_d   = req.port_request_posted ? MRP_TAG_RESET : req.port_request_tag;
    end
  end

  always_ff @(posedge req.clk) begin
    if (!rst_n) begin
      hdr_v_q <= 1'b0;
      addr_q  <= '0;
      tag_q   <= MRP_TAG_RESET;
      cube_q  <= '0;
      cmd_q   <= MRP_CMD_RESET;
      len_q   <= '0;
      wr_q    <= 1'b0;
      pst_q   <= 1'b0;
    end else begin
      hdr_v_q <= hdr_v_d;
      addr_q  <= addr_d;
      tag_q   <= tag_d;
      cube_q  <= cube_d;
      cmd_q   <= cmd_d;
      len_q   <= len_d;
      wr_q    <= wr_d;
      pst_q   <= pst_d;
    end
  end

  // payload beats, one pulse each
  always_comb begin
    dv_d   = 1'b0;
    last_d = 1'b0;
    data_d = data_q;
    if (take) begin
      data_d = req.port_request_data;
      if (state_q == MRP_IDLE) begin
        dv_d   = req.port_request_write;
        last_d = (beats == MRP_BEAT_CNT_W'(1));
      end else begin
        dv_d   = 1'b1;
        last_d = (left_q == MRP_BEAT_CNT_W'(1));
      end
    end
  end

  always_ff @(posedge req.clk) begin
    if (!rst_n) begin
      dv_q   <= 1'b0;
      last_q <= 1'b0;
      data_q <= '0;
    end else begin
      dv_q   <= dv_d;
      last_q <= last_d;
      data_q <= data_d;
    end
  end

  assign sink_hdr_valid  = hdr_v_q;
  assign sink_addr       = addr_q;
  assign sink_tag        = tag_q;
  assign sink_cube       = cube_q;
  assign sink_command    = cmd_q;
  assign sink_len        = len_q;
  assign sink_write      = wr_q;
  assign sink_posted     = pst_q;
  assign sink_data_valid = dv_q;
  assign sink_data       = data_q;
  assign sink_last       = last_q;
endmodule

/* File: mrp_pkg.sv */
package mrp_pkg;
  localparam int MRP_DATA_W_FULL   = 512;
  localparam int MRP_DATA_W_HALF   = 256;
  localparam int MRP_MAX_PAYLOAD_B = 128;
  localparam int MRP_TAG_W         = 9;
  localparam int MRP_CMD_W         = 6;
  localparam int MRP_CUB_W         = 3;
  localparam int MRP_ADDR_W        = 34;
  localparam int MRP_LEN_W         = 8;
  localparam int MRP_MAX_PORTS     = 4;
  localparam int MRP_BEAT_CNT_W    = 3;
  localparam logic [MRP_CMD_W-1:0] MRP_CMD_RESET = 6'h00;
  localparam logic [MRP_TAG_W-1:0] MRP_TAG_RESET = 9'h000;

  typedef enum logic [1:0] {
    MRP_LO_0_255,
    MRP_LO_176,
    MRP_LO_128
  } mrp_split_e;

  // beats needed for a payload of len bytes on a bus of bytes_per_beat
  function automatic logic [MRP_BEAT_CNT_W-1:0] mrp_beats(input logic [MRP_LEN_W-1:0] len,
                                                          input int bytes_per_beat);
    int n;
    n = (int'(len) + bytes_per_beat - 1) / bytes_per_beat;
    if (n < 1) begin
      n = 1;
    end
    return n[MRP_BEAT_CNT_W-1:0];
  endfunction

  // lowest tag of a port given the port count
  function automatic logic [MRP_TAG_W-1:0] mrp_tag_lo(input int ports, input int idx);
    int lo;
    case (ports)
      2: lo = idx * 256;
      3: lo = idx * 176;
      4: lo = idx * 128;
      default: lo = 0;
    endcase
    return lo[MRP_TAG_W-1:0];
  endfunction

  // highest tag of a port given the port count
  function automatic logic [MRP_TAG_W-1:0] mrp_tag_hi(input int ports, input int idx);
    int hi;
    if (idx == ports - 1) begin
      hi = 511;
    end else begin
      hi = int'(mrp_tag_lo(ports, idx + 1)) - 1;
    end
    return hi[MRP_TAG_W-1:0];
  endfunction
endpackage

/* File: mrp_if.sv */
`timescale 1ns/1ps
interface mrp_if #(
  parameter int DATA_W = mrp_pkg::MRP_DATA_W_FULL
) (
  input wire logic clk
);
  logic                          port_accept_ready;
  logic                          port_request_valid;
  logic [DATA_W-1:0]             port_request_data;
  logic [mrp_pkg::MRP_ADDR_W-1:0] port_request_addr;
  logic [mrp_pkg::MRP_TAG_W-1:0]  port_request_tag;
  logic [mrp_pkg::MRP_CUB_W-1:0]  port_request_cube;
  logic [mrp_pkg::MRP_CMD_W-1:0]  port_request_command;
  logic [mrp_pkg::MRP_LEN_W-1:0]  port_request_len;
  logic                          port_request_write;
  logic                          port_request_posted;

  modport device (
    input  clk,
    output port_accept_ready,
    input  port_request_valid,
    input  port_request_data,
    input  port_request_addr,
    input  port_request_tag,
    input  port_request_cube,
    input  port_request_command,
    input  port_request_len,
    input  port_request_write,
    input  port_request_posted
  );

  modport client (
    input  clk,
    input  port_accept_ready,
    output port_request_valid,
    output port_request_data,
    output port_request_addr,
    output port_request_tag,
    output port_request_cube,
    output port_request_command,
    output port_request_len,
    output port_request_write,
    output port_request_posted
  );
endinterface

/* File: mrp_client.sv */
`timescale 1ns/1ps
module mrp_client #(
  parameter int DATA_W    = mrp_pkg::MRP_DATA_W_FULL,
  parameter int NUM_PORTS = 1,
  parameter int PORT_IDX  = 0
) (
  input  wire logic                          rst_n,
  mrp_if.client                              req,
  input  wire logic                          user_valid,
  output logic                               user_ready,
  input  wire logic                          user_write,
  input  wire logic                          user_posted,
  input  wire logic [mrp_pkg::MRP_LEN_W-1:0] user_len,
  input  wire logic [mrp_pkg::MRP_ADDR_W-1:0] user_addr,
  input  wire logic [mrp_pkg::MRP_TAG_W-1:0] user_tag,
  input  wire logic [mrp_pkg::MRP_CUB_W-1:0] user_cube,
  input  wire logic [mrp_pkg::MRP_CMD_W-1:0] user_command,
  input  wire logic                          user_rsp_room,
  input  wire logic [DATA_W-1:0]             user_data,
  output logic                               user_data_next,
  output logic                               user_refused
);
  import mrp_pkg::*;

  localparam int BYTES_PER_BEAT = DATA_W / 8;
  localparam logic [MRP_TAG_W-1:0] TAG_LO = mrp_tag_lo(NUM_PORTS, PORT_IDX);
  localparam logic [MRP_TAG_W-1:0] TAG_HI = mrp_tag_hi(NUM_PORTS, PORT_IDX);

  typedef enum logic [1:0] {
    MRP_C_IDLE,
    MRP_C_SEND
  } mrp_cstate_e;

  mrp_cstate_e               state_q, state_d;
  logic [MRP_BEAT_CNT_W-1:0] left_q, left_d;
  logic                      v_q, v_d, wr_q, wr_d, pst_q, pst_d;
  logic [MRP_LEN_W-1:0]      len_q, len_d;
  logic [MRP_ADDR_W-1:0]     addr_q, addr_d;
  logic [MRP_TAG_W-1:0]      tag_q, tag_d;
  logic [MRP_CUB_W-1:0]      cube_q, cube_d;
  logic [MRP_CMD_W-1:0]      cmd_q, cmd_d;
  logic [DATA_W-1:0]         data_q, data_d;
  logic                      ok, beat_done, ref_q, ref_d;

  // length, tag range and response room are enforced here
  assign ok = (!user_write || (user_len <= MRP_LEN_W'(MRP_MAX_PAYLOAD_B) && user_len != '0))
              && (user_posted || (user_tag >= TAG_LO && user_tag <= TAG_HI))
              && user_rsp_room;
  assign beat_done      = v_q && req.port_accept_ready;
  assign user_ready     = (state_q == MRP_C_IDLE) || (beat_done && left_q == '0);
  assign user_data_next = beat_done && left_q != '0;

  always_comb begin
    state_d = state_q;
    left_d  = left_q;
    v_d     = v_q;
    wr_d    = wr_q;
    pst_d   = pst_q;
    len_d   = len_q;
    addr_d  = addr_q;
    tag_d   = tag_q;
    cube_d  = cube_q;
    cmd_d   = cmd_q;
    data_d  = data_q;
    ref_d   = 1'b0;
    if (beat_done && left_q != '0) begin
      left_d = left_q - MRP_BEAT_CNT_W'(1);
      data_d = user_data;
    end else if (user_ready) begin
      v_d     = 1'b0;
      state_d = MRP_C_IDLE;
      if (user_valid) begin
        ref_d = !ok;
        if (ok) begin
          v_d = 1'b1;
          state_d = MRP_C_SEND;
          wr_d    = user_write;
          pst_d   = user_posted;
          len_d   = user_len;
          addr_d  = user_addr;
          cube_d  = user_cube;
          cmd_d   = user_command;
          tag_d  = user_tag;
          data_d = user_data;
          left_d = user_write ? mrp_beats(user_len, BYTES_PER_BEAT) - MRP_BEAT_CNT_W'(1)
                              : '0;
        end
      end
    end
  end

  always_ff @(posedge req.clk) begin
    if (!rst_n) begin
      state_q <= MRP_C_IDLE;
      left_q  <= '0;
      v_q     <= 1'b0;
      wr_q    <= 1'b0;
      pst_q   <= 1'b0;
      len_q   <= '0;
      addr_q  <= '0;
      tag_q   <= MRP_TAG_RESET;
      cube_q  <= '0;
      cmd_q   <= MRP_CMD_RESET;
      data_q  <= '0;
      ref_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      left_q  <= left_d;
      v_q     <= v_d;
      wr_q    <= wr_d;
      pst_q   <= pst_d;
      len_q   <= len_d;
      addr_q  <= addr_d;
      tag_q   <= tag_d;
      cube_q  <= cube_d;
      cmd_q   <= cmd_d;
      data_q  <= data_d;
      ref_q   <= ref_d;
    end
  end

  assign req.port_request_valid   = v_q;
  assign req.port_request_data    = data_q;
  assign req.port_request_addr    = addr_q;
  assign req.port_request_tag     = tag_q;
  assign req.port_request_cube    = cube_q;
  assign req.port_request_command = cmd_q;
  assign req.port_request_len     = len_q;
  assign req.port_request_write   = wr_q;
  assign req.port_request_posted  = pst_q;
  assign user_refused             = ref_q;
endmodule

/* File: mrp_sva.sv */
`timescale 1ns/1ps
module mrp_sva #(
  parameter int DATA_W    = mrp_pkg::MRP_DATA_W_FULL,
  parameter int NUM_PORTS = 1,
  parameter int PORT_IDX  = 0
) (
  input wire logic                           clk,
  input wire logic                           rst_n,
  input wire logic                           port_accept_ready,
  input wire logic                           port_request_valid,
  input wire logic [mrp_pkg::MRP_ADDR_W-1:0] port_request_addr,
  input wire logic [mrp_pkg::MRP_TAG_W-1:0]  port_request_tag,
  input wire logic [mrp_pkg::MRP_CMD_W-1:0]  port_request_command,
  input wire logic [mrp_pkg::MRP_LEN_W-1:0]  port_request_len,
  input wire logic                           port_request_write,
  input wire logic                           port_request_posted
);
  import mrp_pkg::*;
  localparam int BPB  = DATA_W / 8;
  localparam int MAXB = (DATA_W == MRP_DATA_W_FULL) ? 2 : 4;
  localparam int STEP = (NUM_PORTS == 3) ? 176 : 512 / NUM_PORTS;
  localparam int TLO  = PORT_IDX * STEP;
  localparam int THI  = (PORT_IDX == NUM_PORTS - 1) ? 511 : TLO + STEP - 1;
  logic       take;
  logic [2:0] left_q;
  logic [2:0] left_d;
  assign take = port_request_valid && port_accept_ready;
  // beats still owed by the write in progress
  always_comb begin
    left_d = left_q;
    if (take && left_q != 3'h0) begin
      left_d = left_q - 3'h1;
    end else if (take && port_request_write) begin
      left_d = 3'((int'(port_request_len) + BPB - 1) / BPB - 1);
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      left_q <= 3'h0;
    end else begin
      left_q <= left_d;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence first_take;
    take && left_q == 3'h0;
  endsequence
  sequence in_burst;
    left_q != 3'h0;
  endsequence
  burst_ready_a: assert property (in_burst |-> port_accept_ready)
    else $error("ready dropped inside a burst");
  burst_valid_a: assert property (in_burst |-> port_request_valid)
    else $error("valid dropped inside a burst");
  burst_fields_a: assert property (in_burst |-> $stable(port_request_tag) &&
    $stable(port_request_command)) else $error("tag or command moved inside a burst");
  write_len_a: assert property (first_take ##0 port_request_write |->
    port_request_len inside {[8'h01:8'h80]}) else $error("write length out of range");
  beats_bound_a: assert property (first_take ##0 port_request_write |->
    (int'(port_request_len) + BPB - 1) / BPB <= MAXB) else $error("too many beats");
  tag_range_a: assert property (first_take ##0 !port_request_posted |->
    port_request_tag >= TLO && port_request_tag <= THI) else $error("tag outside port range");
  hold_req_a: assert property (port_request_valid && !port_accept_ready |=>
    port_request_valid && $stable(port_request_addr) && $stable(port_request_len))
    else $error("request changed while refused");
  reset_idle_a: assert property ($rose(rst_n) |-> !port_request_valid)
    else $error("valid high out of reset");
endmodule

/* File: tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb;
  import mrp_pkg::*;
  typedef struct packed {logic [511:0] d; logic [511:0] m; logic l;} mrp_beat_s;
  logic clk, rst_n, sink_ready, user_valid, user_ready, user_write, user_posted;
  logic user_rsp_room, user_data_next, user_refused, sink_hdr_valid, sink_write;
  logic sink_posted, sink_data_valid, sink_last, bp_on;
  logic [7:0] user_len, sink_len;
  logic [33:0] user_addr, sink_addr;
  logic [8:0] user_tag, sink_tag;
  logic [2:0] user_cube, sink_cube;
  logic [5:0] user_command, sink_command;
  logic [511:0] user_data, sink_data;
  int fail_count, compares, exp_ref, seen_ref, seed;
  logic [61:0] hq[$];
  mrp_beat_s bq[$];
  initial begin
    {clk, rst_n, user_valid, user_write, user_posted, bp_on} = 0;
    {sink_ready, user_rsp_room} = 2'h3;
    {user_len, user_addr, user_tag, user_cube, user_command, user_data} = 0;
    {fail_count, compares, exp_ref, seen_ref} = 0;
    seed = 32'hE285;
  end
  always #50 clk = ~clk;
  mrp_if #(.DATA_W(512)) mrp_if_inst (.clk(clk));
  mrp_device mrp_device_inst (.rst_n(rst_n), .req(mrp_if_inst), .sink_ready(sink_ready),
    .sink_hdr_valid(sink_hdr_valid), .sink_addr(sink_addr), .sink_tag(sink_tag),
    .sink_cube(sink_cube), .sink_command(sink_command), .sink_len(sink_len),
    .sink_write(sink_write), .sink_posted(sink_posted), .sink_data_valid(sink_data_valid),
    .sink_data(sink_data), .sink_last(sink_last));
  mrp_client #(.NUM_PORTS(4), .PORT_IDX(1)) mrp_client_inst (.rst_n(rst_n),
    .req(mrp_if_inst), .user_valid(user_valid), .user_ready(user_ready),
    .user_write(user_write), .user_posted(user_posted), .user_len(user_len),
    .user_addr(user_addr), .user_tag(user_tag), .user_cube(user_cube),
    .user_command(user_command), .user_rsp_room(user_rsp_room), .user_data(user_data),
    .user_data_next(user_data_next), .user_refused(user_refused));
  mrp_sva #(.NUM_PORTS(4), .PORT_IDX(1)) mrp_sva_inst (.clk(clk), .rst_n(rst_n),
    .port_accept_ready(mrp_if_inst.port_accept_ready),
    .port_request_valid(mrp_if_inst.port_request_valid),
    .port_request_addr(mrp_if_inst.port_request_addr),
    .port_request_tag(mrp_if_inst.port_request_tag),
    .port_request_command(mrp_if_inst.port_request_command),
    .port_request_len(mrp_if_inst.port_request_len),
    .port_request_write(mrp_if_inst.port_request_write),
    .port_request_posted(mrp_if_inst.port_request_posted));
  task close_out();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task give_up();
    fail_count++;
    $display("[ERR] wait exp done got timeout");
    close_out();
  endtask
  task send(input logic w, p, input logic [7:0] len, input logic [8:0] tag,
            input logic room, input bit keep, input bit bad);
    logic [511:0] d0, d1, m;
    logic [33:0] a;
    logic [2:0] c;
    logic [5:0] cm;
    int n, nb;
    d0 = {16{$random(seed)}};
    d1 = {16{$random(seed)}};
    a = 34'($random(seed));
    c = 3'($random(seed));
    cm = 6'($random(seed));
    nb = (len > 8'h40) ? 2 : 1;
    m = {512{1'b1}} >> (512 - 8 * (int'(len) - 64 * (nb - 1)));
    {user_write, user_posted, user_len, user_tag, user_rsp_room} <= {w, p, len, tag, room};
    {user_addr, user_cube, user_command, user_data, user_valid} <= {a, c, cm, d0, 1'b1};
    n = 0;
    do begin @(posedge clk); n++; end while (user_ready !== 1'b1 && n < 200);
    if (n >= 200) give_up();
    if (bad) exp_ref++;
    else hq.push_back({a, p ? 9'h000 : tag, c, cm, len, w, p});
    if (w && !bad) bq.push_back(nb == 1 ? {d0, m, 1'b1} : {d0, {512{1'b1}}, 1'b0});
    if (w && !bad && nb == 2) bq.push_back({d1, m, 1'b1});
    if (!keep || (w && !bad && nb == 2)) user_valid <= 1'b0;
    if (w && !bad && nb == 2) begin
      user_data <= d1;
      n = 0;
      do begin @(posedge clk); n++; end while (user_data_next !== 1'b1 && n < 200);
      if (n >= 200) give_up();
    end
    if (!keep) @(posedge clk);
  endtask
  task finish_test(input string nm);
    int n;
    n = 0;
    while ((hq.size() + bq.size()) != 0 && n < 400) begin @(posedge clk); n++; end
    if (n >= 400) give_up();
    repeat (3) @(posedge clk);
    `CHK("left", 0, hq.size() + bq.size())
    `CHK("refusals", exp_ref, seen_ref)
    $display("test %s done", nm);
  endtask
  always @(posedge clk) begin
    if (bp_on) sink_ready <= ($random(seed) & 3) != 0;
    if (rst_n && user_refused === 1'b1) seen_ref++;
    if (rst_n && sink_hdr_valid === 1'b1) begin
      `CHK("header", (hq.size() ? hq.pop_front() : 62'h0), {sink_addr, sink_tag,
        sink_cube, sink_command, sink_len, sink_write, sink_posted})
      if (sink_write === 1'b0) `CHK("read_last", 1'b1, sink_last)
    end
    if (rst_n && sink_data_valid === 1'b1) begin
      automatic mrp_beat_s b = '0;
      `CHK("beat_due", 1'b1, bq.size() != 0)
      if (bq.size() != 0) b = bq.pop_front();
      `CHK("beat", b.d & b.m, sink_data & b.m)
      `CHK("last", b.l, sink_last)
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    send(0, 0, 8'h40, 9'h080, 1, 1, 0);
    send(1, 0, 8'h80, 9'h0FF, 1, 1, 0);
    send(1, 0, 8'h64, 9'h0A0, 1, 1, 0);
    send(1, 0, 8'h40, 9'h0A1, 1, 1, 0);
    send(1, 1, 8'h01, 9'h1FF, 1, 0, 0);
    finish_test("back_to_back");
    sink_ready <= 1'b0;
    fork
      send(1, 0, 8'h80, 9'h090, 1, 0, 0);
      begin
        repeat (5) @(posedge clk);
        `CHK("ready_low", 1'b0, mrp_if_inst.port_accept_ready)
        `CHK("valid_held", 1'b1, mrp_if_inst.port_request_valid)
        sink_ready <= 1'b1;
      end
    join
    finish_test("backpressure");
    send(1, 0, 8'h00, 9'h080, 1, 0, 1);
    send(1, 0, 8'h81, 9'h080, 1, 0, 1);
    send(0, 0, 8'h40, 9'h07F, 1, 0, 1);
    send(0, 0, 8'h40, 9'h100, 1, 0, 1);
    send(0, 0, 8'h40, 9'h081, 0, 0, 1);
    finish_test("refusals");
    bp_on = 1'b1;
    repeat (24) send(1'($random(seed)), 0, 8'($unsigned($random(seed)) % 128 + 1),
                     9'h080 + 9'($unsigned($random(seed)) % 128), 1, 1'($random(seed)), 0);
    user_valid <= 1'b0;
    finish_test("random");
    close_out();
  end
endmodule
